/* hdl/pae_cfg.svh */
// Register map, field positions, reset values and timing figures of the alarm evaluator
`ifndef PAE_CFG_SVH
`define PAE_CFG_SVH

// Register byte offsets
`define PAE_OFF_TYPE      8'h00
`define PAE_OFF_DIR       8'h04
`define PAE_OFF_MODE      8'h08
`define PAE_OFF_HYST      8'h0C
`define PAE_OFF_INSPAN    8'h10
`define PAE_OFF_OUTSPAN   8'h14
`define PAE_OFF_LIMIT0    8'h18
`define PAE_LIMIT_STEP    8'h04
`define PAE_OFF_STATUS    8'h28

// Direction register fields
`define PAE_DIR_HIGH_LSB  0
`define PAE_DIR_END_LSB   4
`define PAE_DIR_OUT_LSB   8

// Mode register fields
`define PAE_MODE_LATCH    0
`define PAE_MODE_BLK_LSB  1
`define PAE_MODE_DIAG_LSB 3
`define PAE_MODE_PROG     5
`define PAE_MODE_DUPLEX   6
`define PAE_MODE_DUALRLY  7

// Status register fields
`define PAE_ST_ALARM_LSB  0
`define PAE_ST_SP_LSB     2
`define PAE_ST_BLK_LSB    6
`define PAE_ST_DIAG_LSB   8

// Reset values
`define PAE_RST_TYPE      16'h0000
`define PAE_RST_DIR       12'h000
`define PAE_RST_MODE      8'h00
`define PAE_RST_HYST      10'h000
`define PAE_RST_SPAN      16'h0000
`define PAE_RST_LIMIT     16'h0000

// Alarm type codes; the rest of the type list is a plain level comparison
`define PAE_TYPE_NONE     4'h0
`define PAE_TYPE_EVENT    4'hF

// Hysteresis in tenths of a percent, 0.0 to 100.0 %
`define PAE_HYST_MAX      10'h3E8
`define PAE_HYST_FULL     32'h0000_03E8

// Open output threshold in tenths of a milliamp (3.5 mA)
`define PAE_OPEN_TENTHS   8'h23

// Control cycle timing
`define PAE_CLK_HZ        50000000
`define PAE_CYCLE_MS      167

`endif

/* hdl/pae_pkg.sv */
// Types shared by the alarm evaluator modules
package pae_pkg;

	typedef logic [15:0] pae_val_t;

	typedef enum logic [1:0] {
		PAE_BLK_FREE  = 2'b00,
		PAE_BLK_HOLD  = 2'b01,
		PAE_BLK_QUIET = 2'b10
	} pae_blk_t;

	typedef enum logic [1:0] {
		PAE_SUP_NONE = 2'b00,
		PAE_SUP_A1   = 2'b01,
		PAE_SUP_A2   = 2'b10,
		PAE_SUP_BOTH = 2'b11
	} pae_suppress_t;

endpackage

/* hdl/pae_sp_if.sv */
// Per-setpoint link between the alarm controller and one setpoint evaluator
`timescale 1ns/100ps
interface pae_sp_if;
	import pae_pkg::*;
	pae_val_t value;
	pae_val_t limit;
	pae_val_t hyst;
	logic     dir_high;
	logic     event_mode;
	logic     event_hit;
	logic     enable;
	logic     blocked;
	logic     tick;
	logic     active;
	logic     trip;

	modport ctrl (
		output value, limit, hyst, dir_high, event_mode, event_hit, enable, blocked, tick,
		input  active, trip
	);
	modport eval (
		input  value, limit, hyst, dir_high, event_mode, event_hit, enable, blocked, tick,
		output active, trip
	);
endinterface

/* hdl/pae_sp_eval.sv */
// One alarm setpoint: level comparison with hysteresis, or segment event
`timescale 1ns/100ps
module pae_sp_eval
	import pae_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	pae_sp_if.eval    sp
);
	logic [16:0] lim_w;
	logic [16:0] val_w;
	logic [16:0] hys_w;
	logic        reach_w;
	logic        clear_w;
	logic        cond_w;
	logic        active_q;

	assign val_w = {1'b0, sp.value};
	assign lim_w = {1'b0, sp.limit};
	assign hys_w = {1'b0, sp.hyst};
	// Trip exactly at the setpoint
	assign reach_w = sp.dir_high ? (val_w >= lim_w) : (val_w <= lim_w); // R4 R15
	// Release only past the setpoint by the deadband
	assign clear_w = sp.dir_high ? (val_w + hys_w <= lim_w) : (val_w >= lim_w + hys_w); // R5
	assign cond_w  = sp.event_mode ? sp.event_hit : (reach_w | (active_q & ~clear_w)); // R16
	assign sp.trip   = sp.enable & cond_w;
	assign sp.active = active_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			active_q <= 1'b0;
		end else if (sp.tick) begin
			active_q <= sp.enable & ~sp.blocked & cond_w; // R11 R18
		end
	end
endmodule

/* hdl/pae_top.sv */
// Two-alarm process evaluator with hysteresis, latching, blocking and open-output check
//
// Notes on behaviour
// R1 - Two alarms, two setpoints each, every setpoint with its own type code.
// R2 - Every setpoint holds its own begin or end segment-event choice.
// R3 - Second alarm setpoints off on duplex output unless dual relay fitted.
// R4 - Inactive alarm trips exactly at the setpoint, no deadband offset.
// R5 - Active alarm clears only past the setpoint by the shared deadband, 0-100 %.
// R6 - Input-signal alarms scale the deadband by the input range span.
// R7 - Output-signal alarms scale the deadband by the full output range.
// R8 - Alarm output 1 may be configured latching or non-latching.
// R9 - Latched output 1 stays on until the run/hold key is pressed.
// R10 - Blocking selects none, first alarm, second alarm or both alarms.
// R11 - Blocked alarm stays off until its parameter first leaves alarm.
// R12 - Blocking releases after one full control cycle out of alarm.
// R13 - Diagnostics raise an alarm when current or aux output is below 3.5 mA.
// R14 - Diagnostic target is off, alarm 1 or alarm 2, ORed with its setpoints.
// R15 - Direction bit picks a high or a low trip for each setpoint.
// R16 - Segment event replaces high/low only with programming on and event type.
// R17 - Zero-length program segments raise no segment events.
// R18 - Everything is evaluated once per 167 ms control cycle on sampled values; the code updates latched alarm 1 on the run/hold key at once.
`timescale 1ns/100ps
`include "pae_cfg.svh"
module pae_top
	import pae_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = `PAE_CLK_HZ / 1000 * `PAE_CYCLE_MS
) (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_i,
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [31:0]         reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic      [31:0]         reg_rdata_o,
	input  wire logic [3:0][15:0]    watched_i,
	input  wire logic [7:0]          cur_out_i,
	input  wire logic                cur_out_fitted_i,
	input  wire logic [7:0]          aux_out_i,
	input  wire logic                aux_out_fitted_i,
	input  wire logic                run_hold_key_i,
	input  wire logic                seg_begin_i,
	input  wire logic                seg_end_i,
	input  wire logic                seg_zero_len_i,
	output logic      [1:0]          alarm_o,
	output logic      [3:0]          sp_active_o,
	output logic                     cycle_tick_o
);
	localparam int CW = $clog2(CYCLE_CLKS + 1);

	// Configuration registers
	logic [15:0]     type_q;
	logic [11:0]     dir_q;
	logic [7:0]      mode_q;
	logic [9:0]      hyst_q;
	pae_val_t        in_span_q;
	pae_val_t        out_span_q;
	pae_val_t [3:0]  limit_q;

	// Block state
	logic [CW-1:0]   cnt_q;
	logic            tick_q;
	logic            tick1_q;
	logic [1:0]      alarm_q;
	logic [1:0]      diag_q;
	logic [3:0]      ev_seen_q;
	logic [1:0]      blk_en_q;
	pae_blk_t [1:0]  blk_q;
	logic [31:0]     rdata_q;

	// Decode
	logic            wr_type_w;
	logic            wr_dir_w;
	logic            wr_mode_w;
	logic            wr_hyst_w;
	logic            wr_inspan_w;
	logic            wr_outspan_w;
	logic [3:0]      wr_limit_w;
	logic [31:0]     rd_mux_w;

	// Derived configuration
	logic            latch_w;
	pae_suppress_t   blk_sel_w;
	logic [1:0]      diag_sel_w;
	logic            prog_w;
	logic            second_off_w;
	logic [9:0]      hyst_eff_w;
	pae_val_t        in_hyst_w;
	pae_val_t        out_hyst_w;
	logic            open_w;
	logic [1:0]      diag_to_w;
	logic [1:0]      in_alarm_w;
	logic [1:0]      blocked_w;
	logic [1:0]      cond_w;
	logic [3:0]      ev_pulse_w;
	logic [3:0]      sp_trip_w;
	logic [3:0]      sp_act_w;

	assign wr_type_w    = reg_wr_i && (reg_addr_i == `PAE_OFF_TYPE);
	assign wr_dir_w     = reg_wr_i && (reg_addr_i == `PAE_OFF_DIR);
	assign wr_mode_w    = reg_wr_i && (reg_addr_i == `PAE_OFF_MODE);
	assign wr_hyst_w    = reg_wr_i && (reg_addr_i == `PAE_OFF_HYST);
	assign wr_inspan_w  = reg_wr_i && (reg_addr_i == `PAE_OFF_INSPAN);
	assign wr_outspan_w = reg_wr_i && (reg_addr_i == `PAE_OFF_OUTSPAN);

	assign latch_w      = mode_q[`PAE_MODE_LATCH]; // R8
	assign blk_sel_w    = pae_suppress_t'(mode_q[`PAE_MODE_BLK_LSB +: 2]); // R10
	assign diag_sel_w   = mode_q[`PAE_MODE_DIAG_LSB +: 2];
	assign prog_w       = mode_q[`PAE_MODE_PROG];
	assign second_off_w = mode_q[`PAE_MODE_DUPLEX] & ~mode_q[`PAE_MODE_DUALRLY]; // R3

	// Deadband as a fraction of the chosen span; settings above 100.0 % are clamped
	assign hyst_eff_w = (hyst_q > `PAE_HYST_MAX) ? `PAE_HYST_MAX : hyst_q; // R5
	assign in_hyst_w  = 16'((32'(in_span_q) * 32'(hyst_eff_w)) / `PAE_HYST_FULL); // R6
	assign out_hyst_w = 16'((32'(out_span_q) * 32'(hyst_eff_w)) / `PAE_HYST_FULL); // R7

	// Open-circuit check on either fitted milliamp output
	assign open_w = (cur_out_fitted_i & (cur_out_i < `PAE_OPEN_TENTHS))
		| (aux_out_fitted_i & (aux_out_i < `PAE_OPEN_TENTHS)); // R13
	assign diag_to_w = {diag_sel_w == 2'b10, diag_sel_w == 2'b01}; // R14

	// Control cycle divider
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q   <= '0;
			tick_q  <= 1'b0;
			tick1_q <= 1'b0;
		end else begin
			cnt_q   <= (cnt_q == CW'(CYCLE_CLKS - 1)) ? '0 : cnt_q + CW'(1);
			tick_q  <= (cnt_q == CW'(CYCLE_CLKS - 1)); // R18
			tick1_q <= tick_q;
		end
	end

	// Configuration writes
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			type_q     <= `PAE_RST_TYPE;
			dir_q      <= `PAE_RST_DIR;
			mode_q     <= `PAE_RST_MODE;
			hyst_q     <= `PAE_RST_HYST;
			in_span_q  <= `PAE_RST_SPAN;
			out_span_q <= `PAE_RST_SPAN;
		end else begin
			if (wr_type_w) begin
				type_q <= reg_wdata_i[15:0]; // R1
			end
			if (wr_dir_w) begin
				dir_q <= reg_wdata_i[11:0]; // R2 R15
			end
			if (wr_mode_w) begin
				mode_q <= reg_wdata_i[7:0];
			end
			if (wr_hyst_w) begin
				hyst_q <= reg_wdata_i[9:0];
			end
			if (wr_inspan_w) begin
				in_span_q <= reg_wdata_i[15:0];
			end
			if (wr_outspan_w) begin
				out_span_q <= reg_wdata_i[15:0];
			end
		end
	end

	// Setpoints: limits, segment events and evaluators
	pae_sp_if sp_if [4] ();

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sp
			logic [3:0] type_w;
			logic       is_event_w;

			assign type_w        = type_q[4*g +: 4];
			assign is_event_w    = prog_w & (type_w == `PAE_TYPE_EVENT); // R16
			assign wr_limit_w[g] = reg_wr_i
				&& (reg_addr_i == 8'(`PAE_OFF_LIMIT0 + g * `PAE_LIMIT_STEP));
			assign ev_pulse_w[g] = ~seg_zero_len_i
				& (dir_q[`PAE_DIR_END_LSB + g] ? seg_end_i : seg_begin_i); // R2 R17

			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i) begin
					limit_q[g] <= `PAE_RST_LIMIT;
				end else if (wr_limit_w[g]) begin
					limit_q[g] <= reg_wdata_i[15:0];
				end
			end

			// A segment event caught in the cycle of the tick is kept for the next one
			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i) begin
					ev_seen_q[g] <= 1'b0;
				end else begin
					ev_seen_q[g] <= (ev_seen_q[g] & ~tick_q) | ev_pulse_w[g];
				end
			end

			assign sp_if[g].value      = watched_i[g];
			assign sp_if[g].limit      = limit_q[g];
			assign sp_if[g].hyst       = dir_q[`PAE_DIR_OUT_LSB + g] ? out_hyst_w : in_hyst_w; // R6 R7
			assign sp_if[g].dir_high   = dir_q[`PAE_DIR_HIGH_LSB + g]; // R15
			assign sp_if[g].event_mode = is_event_w;
			assign sp_if[g].event_hit  = ev_seen_q[g]; // R16
			assign sp_if[g].enable     = (type_w != `PAE_TYPE_NONE) & ~((g >= 2) & second_off_w); // R3
			assign sp_if[g].blocked    = blocked_w[g / 2]; // R11
			assign sp_if[g].tick       = tick_q;
			assign sp_trip_w[g]        = sp_if[g].trip;
			assign sp_act_w[g]         = sp_if[g].active;

			pae_sp_eval u_eval (
				.clk_sys_i (clk_sys_i),
				.rst_i     (rst_i),
				.sp        (sp_if[g].eval)
			);
		end
	endgenerate

	// Alarm blocking, one state machine per alarm
	generate
		for (g = 0; g < 2; g++) begin : g_blk
			logic en_w;

			assign en_w          = blk_sel_w[g]; // R10
			assign in_alarm_w[g] = sp_trip_w[2*g] | sp_trip_w[2*g+1];
			assign blocked_w[g]  = (blk_q[g] != PAE_BLK_FREE); // R11

			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i) begin
					blk_en_q[g] <= 1'b0;
					blk_q[g]    <= PAE_BLK_FREE;
				end else begin
					blk_en_q[g] <= en_w;
					if (!en_w) begin
						blk_q[g] <= PAE_BLK_FREE;
					end else if (!blk_en_q[g]) begin
						blk_q[g] <= PAE_BLK_HOLD; // R12
					end else if (tick_q) begin
						unique case (blk_q[g])
							PAE_BLK_HOLD: begin
								blk_q[g] <= in_alarm_w[g] ? PAE_BLK_HOLD : PAE_BLK_QUIET; // R11
							end
							PAE_BLK_QUIET: begin
								blk_q[g] <= in_alarm_w[g] ? PAE_BLK_HOLD : PAE_BLK_FREE; // R12
							end
							PAE_BLK_FREE: begin
								blk_q[g] <= PAE_BLK_FREE;
							end
							default: begin
								blk_q[g] <= PAE_BLK_HOLD;
							end
						endcase
					end
				end
			end
		end
	endgenerate

	// Outputs settle one clock after the evaluators sample
	assign cond_w = {sp_act_w[3] | sp_act_w[2] | diag_q[1],
		sp_act_w[1] | sp_act_w[0] | diag_q[0]}; // R14

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			diag_q  <= 2'b00;
			alarm_q <= 2'b00;
		end else begin
			if (tick_q) begin
				diag_q <= diag_to_w & {2{open_w}}; // R13 R18
			end
			if (tick1_q) begin
				alarm_q[0] <= cond_w[0] | (latch_w & alarm_q[0] & ~run_hold_key_i); // R9
				alarm_q[1] <= cond_w[1];
			end else if (run_hold_key_i && latch_w) begin
				alarm_q[0] <= cond_w[0]; // R9
			end
		end
	end

	// Register read back
	always_comb begin
		rd_mux_w = 32'h0000_0000;
		unique case (reg_addr_i)
			`PAE_OFF_TYPE:    rd_mux_w[15:0] = type_q;
			`PAE_OFF_DIR:     rd_mux_w[11:0] = dir_q;
			`PAE_OFF_MODE:    rd_mux_w[7:0]  = mode_q;
			`PAE_OFF_HYST:    rd_mux_w[9:0]  = hyst_q;
			`PAE_OFF_INSPAN:  rd_mux_w[15:0] = in_span_q;
			`PAE_OFF_OUTSPAN: rd_mux_w[15:0] = out_span_q;
			`PAE_OFF_STATUS: begin
				rd_mux_w[`PAE_ST_ALARM_LSB +: 2] = alarm_q;
				rd_mux_w[`PAE_ST_SP_LSB +: 4]    = sp_act_w;
				rd_mux_w[`PAE_ST_BLK_LSB +: 2]   = blocked_w;
				rd_mux_w[`PAE_ST_DIAG_LSB +: 2]  = diag_q;
			end
			default: begin
				for (int i = 0; i < 4; i++) begin
					if (reg_addr_i == 8'(`PAE_OFF_LIMIT0 + i * `PAE_LIMIT_STEP)) begin
						rd_mux_w[15:0] = limit_q[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= reg_rd_i ? rd_mux_w : 32'h0000_0000;
		end
	end

	assign reg_rdata_o  = rdata_q;
	assign alarm_o      = alarm_q;
	assign sp_active_o  = sp_act_w;
	assign cycle_tick_o = tick_q;
endmodule

/* tb/pae_top_asserts.sv */
// Port assertions for the alarm evaluator
`timescale 1ns/100ps
`include "pae_cfg.svh"
module pae_top_asserts #(
	parameter int unsigned CYCLE_CLKS = 20
) (
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        run_hold_key_i,
	input wire logic [1:0]  alarm_o,
	input wire logic [3:0]  sp_active_o,
	input wire logic        cycle_tick_o
);
	logic [31:0] gap_q;
	logic        seen_q;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Cycles since the last tick; the first tick after reset is not timed
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			gap_q  <= 32'h0;
			seen_q <= 1'b0;
		end else begin
			gap_q  <= cycle_tick_o ? 32'h0 : gap_q + 32'h1;
			seen_q <= seen_q | cycle_tick_o;
		end
	end
	a_tick_one_cycle: assert property (cycle_tick_o |=> !cycle_tick_o)
		else $error("tick pulse longer than one cycle");
	a_tick_period: assert property (cycle_tick_o && seen_q |-> gap_q == CYCLE_CLKS - 1)
		else $error("tick spacing wrong");
	a_sp_on_tick: assert property (!$stable(sp_active_o) |-> $past(cycle_tick_o))
		else $error("setpoint state moved away from a tick");
	a_alarm_on_cause: assert property (!$stable(alarm_o) |-> $past(cycle_tick_o, 2)
		|| $past(run_hold_key_i) || $past(reg_wr_i) || $past(reg_wr_i, 2))
		else $error("alarm output moved without cause");
	a_first_alarm_or: assert property (cycle_tick_o ##2 (|sp_active_o[1:0]) |-> alarm_o[0])
		else $error("first alarm misses its setpoints");
	a_second_alarm_or: assert property ($past(cycle_tick_o, 2) && (|sp_active_o[3:2])
		|-> alarm_o[1])
		else $error("second alarm misses its setpoints");
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside read answer");
	a_unmapped_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) > `PAE_OFF_STATUS
		|-> reg_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_status_mirror: assert property ($past(reg_rd_i) && $past(reg_addr_i) == `PAE_OFF_STATUS
		|-> reg_rdata_o[5:0] == {$past(sp_active_o), $past(alarm_o)})
		else $error("status differs from outputs");
	c_key_on_alarm: cover property (alarm_o[0] && run_hold_key_i);
	c_diag_only: cover property (alarm_o[1] && sp_active_o[3:2] == 2'h0);
	c_status_read: cover property (reg_rd_i && reg_addr_i == `PAE_OFF_STATUS);
endmodule
bind pae_top pae_top_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) i_pae_top_asserts (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .run_hold_key_i(run_hold_key_i),
	.alarm_o(alarm_o), .sp_active_o(sp_active_o), .cycle_tick_o(cycle_tick_o));

/* tb/pae_plant.sv */
// Plant model: process values, output currents, run/hold key, program segments
`timescale 1ns/100ps
module pae_plant
	import pae_pkg::*;
(
	input  wire logic        clk_sys_i,
	output logic [3:0][15:0] pv_o,
	output logic [7:0]       cur_o,
	output logic [7:0]       aux_o,
	output logic             key_o,
	output logic [2:0]       seg_o
);
	initial begin
		pv_o  = '0;
		cur_o = 8'h64;
		aux_o = 8'h64;
		key_o = 1'b0;
		seg_o = 3'h0;
	end
	task automatic pv(input int i, input pae_val_t v);
		@(posedge clk_sys_i);
		pv_o[i] <= v;
	endtask
	task automatic outs(input logic [7:0] c, input logic [7:0] a);
		@(posedge clk_sys_i);
		cur_o <= c;
		aux_o <= a;
	endtask
	task automatic press();
		@(posedge clk_sys_i);
		key_o <= 1'b1;
		@(posedge clk_sys_i);
		key_o <= 1'b0;
	endtask
	// Zero-length flag is a level and outlives the begin or end pulse
	task automatic seg(input logic at_end, input logic zero);
		@(posedge clk_sys_i);
		seg_o <= {zero, at_end, !at_end};
		@(posedge clk_sys_i);
		seg_o <= {zero, 2'h0};
	endtask
endmodule

/* tb/pae_top_test.sv */
// Self-checking bench for the alarm evaluator
`timescale 1ns/100ps
`include "pae_cfg.svh"
module pae_top_test import pae_pkg::*;;
	logic             clk_sys_i;
	logic             rst_i;
	logic [7:0]       reg_addr_i;
	logic [31:0]      reg_wdata_i;
	logic             reg_wr_i;
	logic             reg_rd_i;
	logic [31:0]      reg_rdata_o;
	logic [3:0][15:0] pv;
	logic [7:0]       cur;
	logic [7:0]       aux;
	logic             key;
	logic [2:0]       seg;
	logic [1:0]       fit;
	logic [1:0]       alarm_o;
	logic [3:0]       sp_active_o;
	logic             cycle_tick_o;
	int               err_total;
	int               checked;
	// Setpoint index, value, expected setpoint states, expected alarms
	logic [23:0]      steps [10] = '{{2'h0, 16'h01F4, 4'h1, 2'h1}, {2'h0, 16'h0191, 4'h1, 2'h1},
		{2'h0, 16'h0190, 4'h0, 2'h0}, {2'h1, 16'h00C8, 4'h2, 2'h1}, {2'h1, 16'h012B, 4'h2, 2'h1},
		{2'h1, 16'h012C, 4'h0, 2'h0}, {2'h3, 16'h03E8, 4'h8, 2'h2}, {2'h3, 16'h0321, 4'h8, 2'h2},
		{2'h3, 16'h0320, 4'h0, 2'h0}, {2'h2, 16'h0064, 4'h4, 2'h2}};
	// Mode, current output, aux output, expected alarms
	logic [25:0]      diag [4] = '{{8'h10, 8'h22, 8'h64, 2'h2}, {8'h10, 8'h23, 8'h64, 2'h0},
		{8'h08, 8'h64, 8'h22, 2'h1}, {8'h18, 8'h64, 8'h22, 2'h0}};
	logic [15:0]      lim [4] = '{16'h01F4, 16'h00C8, 16'h0064, 16'h03E8};
	pae_top #(.CYCLE_CLKS(20)) i_pae_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .watched_i(pv), .cur_out_i(cur),
		.cur_out_fitted_i(fit[0]), .aux_out_i(aux), .aux_out_fitted_i(fit[1]),
		.run_hold_key_i(key),
		.seg_begin_i(seg[0]), .seg_end_i(seg[1]), .seg_zero_len_i(seg[2]), .alarm_o(alarm_o),
		.sp_active_o(sp_active_o), .cycle_tick_o(cycle_tick_o));
	pae_plant i_pae_plant (.clk_sys_i(clk_sys_i), .pv_o(pv), .cur_o(cur), .aux_o(aux),
		.key_o(key), .seg_o(seg));
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic final_report();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("reg_rdata_o", e, reg_rdata_o);
	endtask
	// Waits for the next evaluation, then for setpoint and alarm updates to land
	task automatic tick_chk(input logic [3:0] e, input logic [1:0] ea);
		int n;
		@(negedge clk_sys_i);
		for (n = 0; n < 100 && cycle_tick_o !== 1'b1; n++) begin
			@(negedge clk_sys_i);
		end
		if (n == 100) begin
			err_total++;
			final_report();
		end
		repeat (3) @(negedge clk_sys_i);
		chk("sp_active_o", 32'(e), 32'(sp_active_o));
		chk("alarm_o", 32'(ea), 32'(alarm_o));
	endtask
	task automatic both(input pae_val_t a, input pae_val_t c);
		i_pae_plant.pv(0, a);
		i_pae_plant.pv(2, c);
	endtask
	initial begin
		rst_i       = 1'b1;
		reg_addr_i  = 8'h00;
		reg_wdata_i = 32'h0;
		reg_wr_i    = 1'b0;
		reg_rd_i    = 1'b0;
		fit         = 2'b11;
		err_total   = 0;
		checked     = 0;
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 48; a += 4) begin
			rd(8'(a), 32'h0);
		end
		wr(8'h2C, 32'hFFFF_FFFF);
		rd(8'h2C, 32'h0);
		i_pae_plant.pv(1, 16'h012C);
		wr(`PAE_OFF_TYPE, 32'h0000_1111);
		rd(`PAE_OFF_TYPE, 32'h0000_1111);
		wr(`PAE_OFF_DIR, 32'h0000_080D);
		wr(`PAE_OFF_HYST, 32'h0000_07FF);
		rd(`PAE_OFF_HYST, 32'h0000_03FF);
		wr(`PAE_OFF_HYST, 32'h0000_0064);
		wr(`PAE_OFF_INSPAN, 32'h0000_03E8);
		wr(`PAE_OFF_OUTSPAN, 32'h0000_07D0);
		for (int i = 0; i < 4; i++) begin
			wr(`PAE_OFF_LIMIT0 + `PAE_LIMIT_STEP * 8'(i), 32'(lim[i]));
		end
		tick_chk(4'h0, 2'h0);
		foreach (steps[k]) begin
			i_pae_plant.pv(steps[k][23:22], steps[k][21:6]);
			tick_chk(steps[k][5:2], steps[k][1:0]);
		end
		wr(`PAE_OFF_MODE, 32'h0000_0040);
		tick_chk(4'h0, 2'h0);
		wr(`PAE_OFF_MODE, 32'h0000_00C0);
		tick_chk(4'h4, 2'h2);
		rd(`PAE_OFF_STATUS, 32'h0000_0012);
		i_pae_plant.pv(2, 16'h0000);
		foreach (diag[k]) begin
			wr(`PAE_OFF_MODE, 32'(diag[k][25:18]));
			i_pae_plant.outs(diag[k][17:10], diag[k][9:2]);
			tick_chk(4'h0, diag[k][1:0]);
			rd(`PAE_OFF_STATUS, 32'({diag[k][1:0], 6'h00, diag[k][1:0]}));
		end
		// Outputs not fitted never count as open
		@(posedge clk_sys_i);
		fit <= 2'b00;
		wr(`PAE_OFF_MODE, 32'h0000_0008);
		i_pae_plant.outs(8'h22, 8'h22);
		tick_chk(4'h0, 2'h0);
		i_pae_plant.outs(8'h64, 8'h64);
		fit <= 2'b11;
		wr(`PAE_OFF_MODE, 32'h0000_0001);
		i_pae_plant.pv(0, 16'h01F4);
		tick_chk(4'h1, 2'h1);
		i_pae_plant.pv(0, 16'h0000);
		tick_chk(4'h0, 2'h1);
		i_pae_plant.press();
		repeat (2) @(negedge clk_sys_i);
		chk("alarm_o", 32'h0, 32'(alarm_o));
		for (int b = 1; b < 4; b++) begin
			both(16'h0000, 16'h0000);
			tick_chk(4'h0, 2'h0);
			wr(`PAE_OFF_MODE, 32'(b << 1));
			both(16'h01F4, 16'h0064);
			tick_chk({1'b0, !b[1], 1'b0, !b[0]}, {!b[1], !b[0]});
			rd(`PAE_OFF_STATUS, 32'({b[1:0], 1'b0, !b[1], 1'b0, !b[0], !b[1], !b[0]}));
			both(16'h0000, 16'h0000);
			repeat (2) tick_chk(4'h0, 2'h0);
			both(16'h01F4, 16'h0064);
			tick_chk(4'h5, 2'h3);
			wr(`PAE_OFF_MODE, 32'h0);
		end
		both(16'h0000, 16'h0000);
		wr(`PAE_OFF_TYPE, 32'h0000_11FF);
		wr(`PAE_OFF_DIR, 32'h0000_082D);
		wr(`PAE_OFF_MODE, 32'h0000_0020);
		for (int c = 0; c < 4; c++) begin
			i_pae_plant.seg(c[0], c[1]);
			tick_chk({2'h0, !c[1] & c[0], !c[1] & !c[0]}, {1'b0, !c[1]});
			tick_chk(4'h0, 2'h0);
		end
		final_report();
	end
endmodule
